// *** core/spi_chain_pkg.sv ***
// Purpose: Shared constants for the daisy-chained quad switch serial link
// Assumes: 8-bit frames, four switch bits above four check bits
// Notes:   Host timing counts are in sys_clk cycles
package spi_chain_pkg;

  // Frame layout
  localparam int          FRAME_BITS = 8;
  localparam int          SW_BITS    = 4;
  localparam int          SW_MSB     = 7;
  localparam int          SW_LSB     = 4;
  localparam int          CHK_MSB    = 3;
  localparam int          CNT_W      = 3;
  localparam logic [2:0]  CNT_ZERO   = 3'h0;
  localparam logic [2:0]  CNT_ONE    = 3'h1;
  localparam logic [3:0]  NIB_ZERO   = 4'h0;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // Host timing, in sys_clk cycles
  localparam int          SCLK_HALF_CYC = 4;
  localparam int          CS_SETUP_CYC  = 4;
  localparam int          CS_HOLD_CYC   = 4;
  localparam int          CS_GAP_CYC    = 8;
  localparam int          TMR_W         = 4;

  // Check nibble: {O2^O4, O1^O3, O1^O2^O3^O4, its inverse}; sw[3] is O4
  function automatic logic [3:0] check_bits(input logic [3:0] sw);
    logic all_x;
    all_x = ^sw;
    check_bits = {sw[1] ^ sw[3], sw[0] ^ sw[2], all_x, ~all_x};
  endfunction

endpackage

// *** core/spi_chain_if.sv ***
// Purpose: One hop of the serial chain between host and one device
// Assumes: Testbench resolves miso from miso_oe
// Notes:   For a chain, one instance per hop, joined by the testbench
`timescale 1ns/10ps
interface spi_chain_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input  miso,
    input  miso_oe
  );

  modport device (
    input  sclk,
    input  cs_n,
    input  mosi,
    output miso,
    output miso_oe
  );
endinterface

// *** core/switch_spi_host.sv ***
// Purpose: Host end that drives a chain of NDEV switch devices
// Assumes: sclk made from sys_clk by a divider; miso synchronised
// Notes:   Byte for the farthest device leaves first
`timescale 1ns/10ps
module switch_spi_host
  import spi_chain_pkg::*;
#(
  parameter int NDEV = 4
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  // User side
  input  wire logic                   start,
  input  wire logic [NDEV*SW_BITS-1:0] sw_cmds,
  output logic                        busy,
  output logic                        done,
  output logic [NDEV*FRAME_BITS-1:0]  rx_diag,
  // Link
  spi_chain_if.host                   link
);
  localparam int TOTAL = NDEV * FRAME_BITS;

  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} hstate_t;

  hstate_t                  state_ff;
  logic [TMR_W-1:0]         tmr_ff;
  logic [$clog2(TOTAL+1)-1:0] bits_ff;
  logic [TOTAL-1:0]         tx_ff;
  logic [TOTAL-1:0]         rx_ff;
  logic                     sclk_ff;
  logic                     cs_n_ff;
  logic                     mosi_ff;
  logic                     done_ff;
  logic                     miso_m_ff;
  logic                     miso_s_ff;
  logic [TOTAL-1:0]         nxt_tx;
  logic                     tmr_end;

  always_comb begin
    nxt_tx = '0;
    for (int k = 0; k < NDEV; k++) begin
      nxt_tx[k*FRAME_BITS +: FRAME_BITS] = {sw_cmds[k*SW_BITS +: SW_BITS],
                                            check_bits(sw_cmds[k*SW_BITS +: SW_BITS])};
    end
  end

  assign tmr_end = (tmr_ff == '0);

  // Pin input: two stages before use
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      miso_m_ff <= 1'b0;
      miso_s_ff <= 1'b0;
    end else begin
      miso_m_ff <= link.miso;
      miso_s_ff <= miso_m_ff;
    end
  end

  // Frame sequencer; one clock and select for all
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_ff <= H_IDLE;
      tmr_ff   <= '0;
      bits_ff  <= '0;
      tx_ff    <= '0;
      rx_ff    <= '0;
      sclk_ff  <= 1'b0;
      cs_n_ff  <= 1'b1;
      mosi_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (!tmr_end) begin
        tmr_ff <= tmr_ff - 1'b1;
      end
      case (state_ff)
        H_IDLE: begin
          if (start) begin
            tx_ff    <= nxt_tx;
            mosi_ff  <= nxt_tx[TOTAL-1];
            cs_n_ff  <= 1'b0;
            bits_ff  <= '0;
            tmr_ff   <= TMR_W'(CS_SETUP_CYC);
            state_ff <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (tmr_end) begin
            tmr_ff   <= TMR_W'(SCLK_HALF_CYC);
            state_ff <= H_LOW;
          end
        end
        H_LOW: begin
          if (tmr_end) begin
            // sample just before the rising edge
            rx_ff    <= {rx_ff[TOTAL-2:0], miso_s_ff};
            sclk_ff  <= 1'b1;
            tmr_ff   <= TMR_W'(SCLK_HALF_CYC);
            state_ff <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_end) begin
            sclk_ff <= 1'b0;
            bits_ff <= bits_ff + 1'b1;
            tmr_ff  <= TMR_W'(SCLK_HALF_CYC);
            if (bits_ff == ($clog2(TOTAL+1))'(TOTAL - 1)) begin
              tmr_ff   <= TMR_W'(CS_HOLD_CYC);
              state_ff <= H_HOLD;
            end else begin
              // new data after the falling edge
              tx_ff    <= {tx_ff[TOTAL-2:0], 1'b0};
              mosi_ff  <= tx_ff[TOTAL-2];
              state_ff <= H_LOW;
            end
          end
        end
        H_HOLD: begin
          if (tmr_end) begin
            cs_n_ff  <= 1'b1;
            done_ff  <= 1'b1;
            tmr_ff   <= TMR_W'(CS_GAP_CYC);
            state_ff <= H_GAP;
          end
        end
        H_GAP: begin
          // Lets every device see select high before the next frame
          if (tmr_end) begin
            state_ff <= H_IDLE;
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // Busy follows the sequencer
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_ff != H_IDLE) || start;
    end
  end

  assign link.sclk = sclk_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;
  assign done      = done_ff;
  assign rx_diag   = rx_ff;
endmodule

// *** core/switch_spi_device.sv ***
// Purpose: Device end: 8-bit chainable shift path for four switches
// Assumes: Link logic on sclk; output stage reset by cs_n high, shift words cleared after commit; status on sys_clk
// Notes:   Commit happens in sys_clk domain after select rises
`timescale 1ns/10ps
// What this block does
// - Host data in, each output feeds next
// - Clock and select shared by all devices
// - Byte: four switch bits, then check bits
// - Byte in leaves on output eight pulses later
// - Own diagnostics out in first eight pulses
// - New byte displaces the previously held byte
// - Upstream diagnostics pass through toward host
// - Host sends farthest device byte first
// - Select rise applies all configurations together
// - Faults masked while switch clamps inductive energy
// - Sample on rise, shift on fall
// - Bad check bits: keep switches, flag fault
// - Pulse count not multiple of eight flags
// - Select fall snapshots live and held faults
module switch_spi_device
  import spi_chain_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // Field status, asynchronous
  input  wire logic [SW_BITS-1:0] overheat_raw,
  input  wire logic [SW_BITS-1:0] clamp_raw,
  // User outputs
  output logic [SW_BITS-1:0]      switch_on,
  output logic                    fault_n,
  output logic                    serial_fault_n,
  // Link
  spi_chain_if.device             link
);
  // Link-domain state
  logic [FRAME_BITS-1:0] shift_ff;
  logic [CNT_W-1:0]      cnt_ff;
  logic                  got_ff;
  logic                  sdo_ff;
  logic                  started_ff;
  // System-domain state
  logic                  cs_m_ff;
  logic                  cs_s_ff;
  logic                  cs_d_ff;
  logic [SW_BITS-1:0]    ovh_m_ff;
  logic [SW_BITS-1:0]    ovh_s_ff;
  logic [SW_BITS-1:0]    clp_m_ff;
  logic [SW_BITS-1:0]    clp_s_ff;
  logic [SW_BITS-1:0]    sw_ff;
  logic [SW_BITS-1:0]    held_ff;
  logic [FRAME_BITS-1:0] diag_ff;
  logic                  fault_n_ff;
  logic                  sfault_n_ff;
  logic                  got_clr_ff;
  logic [SW_BITS-1:0]    live_thermal_fault_bits;
  logic                  commit;
  logic                  frame_err;
  logic [SW_BITS-1:0]    cmd_sw;

  // sample on rising edge while selected.
  // The frame words must outlive the select rise, because the commit in the
  // system domain reads them a few cycles later. Clearing them on select high
  // would wipe the command before it is applied, so they are cleared only
  // once the commit has taken them, while sclk is known to be idle.
  // Pulses that arrive while deselected are ignored by the enable below.
  always_ff @(posedge link.sclk or posedge got_clr_ff) begin
    if (got_clr_ff) begin
      shift_ff <= BYTE_ZERO;
      cnt_ff   <= CNT_ZERO;
      got_ff   <= 1'b0;
    end else if (!link.cs_n) begin
      got_ff <= 1'b1;
      cnt_ff <= cnt_ff + CNT_ONE;
      if (!got_ff) begin
        // own diagnostics lead the first byte
        shift_ff <= {diag_ff[FRAME_BITS-2:0], link.mosi};
      end else begin
        // new bits push older ones onward
        shift_ff <= {shift_ff[FRAME_BITS-2:0], link.mosi};
      end
    end
  end

  // output moves on the falling edge
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      sdo_ff     <= 1'b0;
      started_ff <= 1'b0;
    end else begin
      sdo_ff     <= shift_ff[FRAME_BITS-1];
      started_ff <= 1'b1;
    end
  end

  // first bit shows before any falling edge; tri-state when deselected
  assign link.miso    = started_ff ? sdo_ff : diag_ff[FRAME_BITS-1];
  assign link.miso_oe = ~link.cs_n;

  // Two-stage synchronisers for select and field status.
  // Only the second stage feeds logic; the third select stage exists just
  // to find the rising edge of the synchronised select.
  // Field status may glitch; a single-cycle blip still lands in held faults.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cs_m_ff  <= 1'b1;
      cs_s_ff  <= 1'b1;
      cs_d_ff  <= 1'b1;
      ovh_m_ff <= NIB_ZERO;
      ovh_s_ff <= NIB_ZERO;
      clp_m_ff <= NIB_ZERO;
      clp_s_ff <= NIB_ZERO;
    end else begin
      cs_m_ff  <= link.cs_n;
      cs_s_ff  <= cs_m_ff;
      cs_d_ff  <= cs_s_ff;
      ovh_m_ff <= overheat_raw;
      ovh_s_ff <= ovh_m_ff;
      clp_m_ff <= clamp_raw;
      clp_s_ff <= clp_m_ff;
    end
  end

  // no fault while clamping; off channels never fault
  assign live_thermal_fault_bits = ovh_s_ff & sw_ff & ~clp_s_ff;

  // Link words are quiet here: sclk has stopped before select rises.
  // A frame with no pulses leaves got_ff low and so commits nothing.
  assign commit = cs_s_ff & ~cs_d_ff & got_ff;
  assign cmd_sw = shift_ff[SW_MSB:SW_LSB];
  assign frame_err = (shift_ff[CHK_MSB:0] != check_bits(cmd_sw)) || (cnt_ff != CNT_ZERO);

  // Clear request for the link words: high in reset and in the cycle after
  // a commit. Select is high and sclk idle then, so the asynchronous clear
  // never meets a live sclk edge. The host gap leaves room for it to finish
  // before the next frame starts.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      got_clr_ff <= 1'b1;
    end else begin
      got_clr_ff <= commit;
    end
  end

  // apply last byte on select rise
  // Every device sees the same select, so all of them switch in one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sw_ff <= NIB_ZERO;
    end else if (commit && !frame_err) begin
      sw_ff <= cmd_sw;
    end
  end

  // serial fault stands until next frame end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sfault_n_ff <= 1'b1;
    end else if (commit) begin
      sfault_n_ff <= ~frame_err;
    end
  end

  // Held faults: a new event wins over the clear at frame end.
  // A frame with a serial fault leaves them standing, so no event is lost
  // to a corrupted read.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      held_ff <= NIB_ZERO;
    end else if (commit && !frame_err) begin
      held_ff <= live_thermal_fault_bits;
    end else begin
      held_ff <= held_ff | live_thermal_fault_bits;
    end
  end

  // snapshot frozen while selected, so the frame sees select-fall state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      diag_ff <= BYTE_ZERO;
    end else if (cs_s_ff) begin
      diag_ff <= {live_thermal_fault_bits, held_ff | live_thermal_fault_bits};
    end
  end

  // fault pin follows masked live faults
  // Clamping channels are masked, so load turn-off never trips the pin
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_n_ff <= 1'b1;
    end else begin
      fault_n_ff <= ~|live_thermal_fault_bits;
    end
  end

  assign switch_on      = sw_ff;
  assign fault_n        = fault_n_ff;
  assign serial_fault_n = sfault_n_ff;
endmodule

// *** tb/spi_link_checker.sv ***
// Purpose: Timing checks on the host hop of the switch chain
// Assumes: Clock, select and mosi come from host flops on sys_clk
// Notes:   Phase counts follow the host divider settings
`timescale 1ns/10ps
module spi_link_checker #(
  parameter int NDEV = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  logic       sclk_q_ff;
  logic [7:0] pulses_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Delayed serial clock for edge detection
  always_ff @(posedge sys_clk) begin
    sclk_q_ff <= sclk;
  end
  // Rising pulses in a frame; cleared while deselected so each frame counts alone
  always_ff @(posedge sys_clk) begin
    if (sys_rst || cs_n) begin
      pulses_ff <= 8'h00;
    end else if (sclk && !sclk_q_ff) begin
      pulses_ff <= pulses_ff + 8'h01;
    end
  end
  idle_low_a: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  out_enable_a: assert property (miso_oe == !cs_n)
    else $error("miso enable not tied to select");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  miso_hold_a: assert property (sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while sclk high");
  high_phase_a: assert property ($rose(sclk) |-> sclk[*5] ##1 !sclk)
    else $error("sclk high phase length wrong");
  pulse_count_a: assert property ($rose(cs_n) |-> pulses_ff == 8'(8 * NDEV))
    else $error("frame pulse count wrong");
  frame_bound_a: assert property ($fell(cs_n) |-> ##[1:1000] $rose(cs_n))
    else $error("frame never ended");
  select_gap_a: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("select gap too short");
  frame_c: cover property ($rose(cs_n) && pulses_ff == 8'h18);
  diag_c: cover property (sclk && miso);
  start_c: cover property ($fell(cs_n));
endmodule

// *** tb/tb.sv ***
// Purpose: Chain of three devices behind the host, plus one lone device
// Assumes: Lone device link is bit-banged with a 12 ns gated clock
// Notes:   Released miso shows a toggling level, never a held value
`timescale 1ns/10ps
module tb;
  import spi_chain_pkg::*;
  localparam int ND = 3;
  logic                  sys_clk;
  logic                  sys_rst;
  logic                  start;
  logic [ND*SW_BITS-1:0] sw_cmds;
  logic                  busy;
  logic                  done;
  logic [ND*8-1:0]       rx_diag;
  logic [3:0]            ovh [ND];
  logic [3:0]            clp [ND];
  logic [3:0]            sw_on [ND+1];
  logic                  flt_n [ND+1];
  logic                  sfn [ND+1];
  logic                  feed [ND+1];
  logic                  tgl = 1'b0;
  int                    errors;
  int                    checked;
  int                    cyc = 0;
  spi_chain_if h_if ();
  spi_chain_if d_if [ND] ();
  spi_chain_if bx_if ();
  switch_spi_host #(.NDEV(ND)) switch_spi_host_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start),
    .sw_cmds(sw_cmds), .busy(busy), .done(done), .rx_diag(rx_diag), .link(h_if));
  spi_link_checker #(.NDEV(ND)) spi_link_checker_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .sclk(h_if.sclk),
    .cs_n(h_if.cs_n), .mosi(h_if.mosi), .miso(h_if.miso), .miso_oe(h_if.miso_oe));
  // Chain wiring: shared clock and select, each output feeds the next input
  assign feed[0] = h_if.mosi;
  assign h_if.miso = feed[ND];
  assign h_if.miso_oe = d_if[ND-1].miso_oe;
  for (genvar k = 0; k < ND; k++) begin : g_dev
    assign d_if[k].sclk = h_if.sclk;
    assign d_if[k].cs_n = h_if.cs_n;
    assign d_if[k].mosi = feed[k];
    assign feed[k+1] = d_if[k].miso_oe ? d_if[k].miso : tgl;
    switch_spi_device switch_spi_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .overheat_raw(ovh[k]),
      .clamp_raw(clp[k]), .switch_on(sw_on[k]), .fault_n(flt_n[k]), .serial_fault_n(sfn[k]), .link(d_if[k]));
  end
  switch_spi_device switch_spi_device_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .overheat_raw(4'h0),
    .clamp_raw(4'h0), .switch_on(sw_on[ND]), .fault_n(flt_n[ND]), .serial_fault_n(sfn[ND]), .link(bx_if));
  // Clock, and a fill pattern for undriven lines
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) tgl <= ~tgl;
  // Hang guard: a full run takes under 2000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_bit(input string s, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic cmp_nib(input string s, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmp_diag(input string s, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [7:0] frame_of(input logic [3:0] sw);
    frame_of = {sw, sw[1] ^ sw[3], sw[0] ^ sw[2], ^sw, ~^sw};
  endfunction
  // One host frame; leading wait covers the host gap and input sync
  task automatic run_chain(input logic [ND*SW_BITS-1:0] cmds);
    int n;
    repeat (16) @(posedge sys_clk);
    sw_cmds <= cmds;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    @(posedge sys_clk);
    cmp_bit("busy", 1'b1, busy);
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 2000) errors++;
  endtask
  // Lone device frame of n bits, MSB first; miso read just before each rise
  task automatic bx_frame(input logic [15:0] bits, input int n, output logic [15:0] got);
    got = 16'h0000;
    bx_if.cs_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      bx_if.mosi = bits[i];
      #6;
      got[i] = bx_if.miso;
      bx_if.sclk = 1'b1;
      #6;
      bx_if.sclk = 1'b0;
    end
    @(posedge sys_clk);
    bx_if.cs_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
  endtask
  // Each device gets its own byte, and all switch together
  task automatic t_apply();
    logic same;
    same = 1'b1;
    run_chain({4'hE, 4'h7, 4'hA});
    repeat (12) begin
      @(posedge sys_clk);
      if ((sw_on[0] === 4'hA) != (sw_on[1] === 4'h7) || (sw_on[1] === 4'h7) != (sw_on[2] === 4'hE)) same = 1'b0;
    end
    cmp_bit("together", 1'b1, same);
    cmp_nib("dev0 sw", 4'hA, sw_on[0]);
    cmp_nib("dev1 sw", 4'h7, sw_on[1]);
    cmp_nib("dev2 sw", 4'hE, sw_on[2]);
    cmp_diag("quiet diag", 24'h00_0000, rx_diag);
    cmp_bit("chain flag", 1'b1, sfn[ND-1]);
    cmp_bit("chain fault pin", 1'b1, flt_n[ND-1]);
  endtask
  // Live and held faults, a clamped channel, then held bits clearing
  task automatic t_diag();
    ovh[0] <= 4'h2;
    clp[0] <= 4'h2;
    ovh[1] <= 4'h5;
    ovh[2] <= 4'h6;
    clp[2] <= 4'h2;
    run_chain({4'hE, 4'h7, 4'hA});
    cmp_diag("live diag", 24'h44_5500, rx_diag);
    cmp_bit("clamped fault", 1'b1, flt_n[0]);
    cmp_bit("dev1 fault", 1'b0, flt_n[1]);
    ovh[1] <= 4'h0;
    run_chain({4'hE, 4'h7, 4'hA});
    cmp_diag("held diag", 24'h44_0500, rx_diag);
    run_chain({4'hE, 4'h7, 4'hA});
    cmp_diag("cleared diag", 24'h44_0000, rx_diag);
  endtask
  // Bad check bits, odd count, then two bytes where the last one wins
  task automatic t_lone();
    logic [15:0] got;
    bx_frame({8'h00, frame_of(4'h6)}, 8, got);
    cmp_nib("good byte", 4'h6, sw_on[ND]);
    cmp_bit("good flag", 1'b1, sfn[ND]);
    bx_frame({8'h00, frame_of(4'h9) ^ 8'h01}, 8, got);
    cmp_nib("bad check kept", 4'h6, sw_on[ND]);
    cmp_bit("bad check flag", 1'b0, sfn[ND]);
    bx_frame({4'h0, 4'h5, frame_of(4'h9)}, 12, got);
    cmp_nib("odd count kept", 4'h6, sw_on[ND]);
    cmp_bit("odd count flag", 1'b0, sfn[ND]);
    bx_frame({8'h3C, frame_of(4'h9)}, 16, got);
    cmp_nib("last byte", 4'h9, sw_on[ND]);
    cmp_bit("flag cleared", 1'b1, sfn[ND]);
    cmp_diag("shift out", 24'h00_003C, {8'h00, got});
  endtask
  // Reset with both selects high, then the scenarios
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    start = 1'b0;
    sw_cmds = '0;
    bx_if.sclk = 1'b0;
    bx_if.cs_n = 1'b1;
    bx_if.mosi = 1'b0;
    errors = 0;
    checked = 0;
    foreach (ovh[k]) begin
      ovh[k] = 4'h0;
      clp[k] = 4'h0;
    end
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_apply();
    t_diag();
    t_lone();
    summarize();
  end
endmodule
